// ===== hw/dma_ctrl.sv
// Two-channel cycle-stealing DMA controller with APB registers and a
// single-access memory master port shared with the CPU.
// The memory port answers each request with a one-cycle mem_ack; byte data uses bits 7:0.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
module dma_ctrl
    import dma_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PADDR_W-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Request sources
    input  wire logic                  ext_irq_pin_zero,
    input  wire logic                  ext_irq_pin_one,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    // Memory master, stolen from the CPU
    output mem_cmd_t                   mem_cmd,
    input  wire logic [DATA_W-1:0]     mem_rdata,
    input  wire logic                  mem_ack,
    input  wire logic                  cpu_bus_req,
    input  wire logic                  cpu_cycle_done,
    // Completion requests to the interrupt controller
    output logic [NUM_CH-1:0]          done_irq
);
    chan_cfg_t              cfg_reg    [NUM_CH];
    logic [SEL_W-1:0]       sel_reg    [NUM_CH];
    logic [ADDR_W-1:0]      src_reg    [NUM_CH];
    logic [ADDR_W-1:0]      dst_reg    [NUM_CH];
    logic [CNT_W-1:0]       reload_reg [NUM_CH];
    logic [CNT_W-1:0]       count_reg  [NUM_CH];
    logic [ADDR_W-1:0]      fwd_reg    [NUM_CH];
    logic [NUM_CH-1:0]      first_reg;
    logic [NUM_CH-1:0]      reqbit_reg;
    logic [NUM_CH-1:0]      swtrig_reg;
    logic [NUM_CH-1:0]      req_event;
    logic [NUM_CH-1:0]      pending;
    xfer_state_t            state_reg;
    logic                   ch_reg;
    logic                   part_reg;
    logic [ADDR_W-1:0]      cur_src_reg;
    logic [ADDR_W-1:0]      cur_dst_reg;
    logic [DATA_W-1:0]      buf_reg;
    mem_cmd_t               cmd_reg;
    logic [31:0]            prdata_reg;
    logic                   pslverr_reg;
    logic [NUM_CH-1:0]      done_reg;

    logic                   wr_acc;
    logic                   ach;
    logic [4:0]             aoff;
    logic                   split;
    logic                   last_part;
    logic [ADDR_W-1:0]      acc_addr;
    logic                   acc_blocked;
    logic                   acc_done;
    logic                   start;
    logic                   start_ch;
    logic                   finish;

    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign mem_cmd = cmd_reg;
    assign done_irq = done_reg;

    assign wr_acc = psel & penable & pwrite;
    assign ach    = paddr[CH_BIT];
    assign aoff   = paddr[4:0];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_src
            dma_req_select u_sel (
                .clk              (clk),
                .srst             (srst),
                .sel              (sel_reg[g]),
                .ext_irq_pin_zero (ext_irq_pin_zero),
                .ext_irq_pin_one  (ext_irq_pin_one),
                .periph_irq       (periph_irq),
                .sw_trig          (swtrig_reg[g]),
                .req_event        (req_event[g])
            );
            assign pending[g] = cfg_reg[g].en & reqbit_reg[g];
        end
    endgenerate

    // Access sequencing
    assign split     = ~cfg_reg[ch_reg].byte_mode &
                       ((state_reg == ST_READ) ? cur_src_reg[0] : cur_dst_reg[0]);
    assign last_part = ~split | part_reg;
    assign acc_addr  = ((state_reg == ST_READ) ? cur_src_reg : cur_dst_reg) +
                       (part_reg ? STEP_BYTE : ADDR_ZERO);
    assign acc_blocked = (acc_addr >= WIN_LO) && (acc_addr <= WIN_HI);
    assign acc_done  = (cmd_reg.req & mem_ack) | (acc_blocked & ~cmd_reg.req);
    assign start     = (state_reg == ST_IDLE) && (pending != '0);
    assign start_ch  = ~pending[0];
    assign finish    = (state_reg == ST_WRITE) && acc_done && last_part;

    // Transfer sequencer, one unit per stolen access group
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            ch_reg    <= 1'b0;
            part_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        ch_reg    <= start_ch;
                        part_reg  <= 1'b0;
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (acc_done) begin
                        part_reg  <= ~last_part;
                        state_reg <= last_part ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (acc_done) begin
                        part_reg  <= ~last_part;
                        state_reg <= last_part ? ST_YIELD : ST_WRITE;
                    end
                end
                ST_YIELD: begin
                    if (cpu_cycle_done || !cpu_bus_req) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Memory command and data buffer
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_reg <= '0;
            buf_reg <= '0;
        end else if (cmd_reg.req) begin
            if (mem_ack) begin
                cmd_reg.req <= 1'b0;
                if (!cmd_reg.we) begin
                    if (!cmd_reg.byte_mode) begin
                        buf_reg <= mem_rdata;
                    end else if (part_reg) begin
                        buf_reg[15:8] <= mem_rdata[7:0];
                    end else begin
                        buf_reg[7:0] <= mem_rdata[7:0];
                    end
                end
            end
        end else if ((state_reg == ST_READ || state_reg == ST_WRITE) && !acc_blocked) begin
            cmd_reg.req       <= 1'b1;
            cmd_reg.we        <= (state_reg == ST_WRITE);
            cmd_reg.byte_mode <= cfg_reg[ch_reg].byte_mode | split;
            cmd_reg.addr      <= acc_addr;
            cmd_reg.wdata     <= !split ? buf_reg : (part_reg ? {8'h00, buf_reg[15:8]}
                                                              : {8'h00, buf_reg[7:0]});
        end
    end

    // Request bits: a new event wins over any clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            reqbit_reg <= '0;
            swtrig_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                swtrig_reg[i] <= wr_acc && (ach == i[0]) && (aoff == OFF_CTRL) && pwdata[CTRL_SWT];
                if (req_event[i]) begin
                    reqbit_reg[i] <= 1'b1;
                end else if (start && start_ch == i[0]) begin
                    reqbit_reg[i] <= 1'b0;
                end else if (wr_acc && ach == i[0] && aoff == OFF_CTRL && !pwdata[CTRL_REQ]) begin
                    reqbit_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Channel state: transfer progress first, software writes last
    always_ff @(posedge clk) begin
        if (srst) begin
            done_reg    <= '0;
            first_reg   <= '0;
            cur_src_reg <= ADDR_ZERO;
            cur_dst_reg <= ADDR_ZERO;
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_reg[i]    <= CFG_RESET;
                sel_reg[i]    <= SEL_SW;
                src_reg[i]    <= ADDR_ZERO;
                dst_reg[i]    <= ADDR_ZERO;
                reload_reg[i] <= CNT_ZERO;
                count_reg[i]  <= CNT_ZERO;
                fwd_reg[i]    <= ADDR_ZERO;
            end
        end else begin
            done_reg <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (start && start_ch == i[0]) begin
                    first_reg[i] <= 1'b0;
                    if (first_reg[i]) begin
                        fwd_reg[i]   <= cfg_reg[i].src_fwd ? src_reg[i] : dst_reg[i];
                        count_reg[i] <= reload_reg[i];
                    end
                    // The forward side follows the pointer, the other stays fixed
                    cur_src_reg <= (cfg_reg[i].src_fwd && !first_reg[i]) ? fwd_reg[i] : src_reg[i];
                    cur_dst_reg <= (cfg_reg[i].dst_fwd && !first_reg[i]) ? fwd_reg[i] : dst_reg[i];
                end
                if (finish && ch_reg == i[0]) begin
                    fwd_reg[i] <= fwd_reg[i] + (cfg_reg[i].byte_mode ? STEP_BYTE : STEP_WORD);
                    if (count_reg[i] == CNT_ZERO) begin
                        done_reg[i] <= 1'b1;
                        if (cfg_reg[i].rpt) begin
                            count_reg[i] <= reload_reg[i];
                        end else begin
                            cfg_reg[i].en <= 1'b0;
                        end
                    end else begin
                        count_reg[i] <= count_reg[i] - CNT_ONE;
                    end
                end
                if (wr_acc && ach == i[0]) begin
                    case (aoff)
                        OFF_CTRL: begin
                            cfg_reg[i].en        <= pwdata[CTRL_EN];
                            cfg_reg[i].rpt       <= pwdata[CTRL_RPT];
                            cfg_reg[i].byte_mode <= pwdata[CTRL_BYTE];
                            cfg_reg[i].src_fwd   <= pwdata[CTRL_SFWD];
                            cfg_reg[i].dst_fwd   <= pwdata[CTRL_DFWD];
                            if (pwdata[CTRL_EN]) begin
                                first_reg[i] <= 1'b1;
                            end
                        end
                        OFF_SEL: sel_reg[i] <= pwdata[SEL_W-1:0];
                        OFF_SRC: begin
                            if (cfg_reg[i].src_fwd || !cfg_reg[i].en) begin
                                src_reg[i] <= pwdata[ADDR_W-1:0];
                            end
                        end
                        OFF_DST: begin
                            if (cfg_reg[i].dst_fwd || !cfg_reg[i].en) begin
                                dst_reg[i] <= pwdata[ADDR_W-1:0];
                            end
                        end
                        OFF_RELOAD: reload_reg[i] <= pwdata[CNT_W-1:0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // APB read data and error, captured in the setup cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata_reg  <= RD_ZERO;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= 1'b0;
            case (aoff)
                OFF_CTRL: prdata_reg <= 32'({1'b0, reqbit_reg[ach], cfg_reg[ach].dst_fwd,
                                             cfg_reg[ach].src_fwd, cfg_reg[ach].byte_mode,
                                             cfg_reg[ach].rpt, cfg_reg[ach].en});
                OFF_SEL:    prdata_reg <= 32'(sel_reg[ach]);
                OFF_SRC:    prdata_reg <= 32'((cfg_reg[ach].en && cfg_reg[ach].src_fwd)
                                              ? fwd_reg[ach] : src_reg[ach]);
                OFF_DST:    prdata_reg <= 32'((cfg_reg[ach].en && cfg_reg[ach].dst_fwd)
                                              ? fwd_reg[ach] : dst_reg[ach]);
                OFF_RELOAD: prdata_reg <= 32'(reload_reg[ach]);
                OFF_COUNT:  prdata_reg <= 32'(count_reg[ach]);
                default: begin
                    prdata_reg  <= RD_ZERO;
                    pslverr_reg <= 1'b1;
                end
            endcase
        end
    end

    a_prio_zero: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_IDLE && pending == 2'b11) |=> (state_reg == ST_READ && ch_reg == 1'b0))
        else $error("channel one served ahead of channel zero");

    a_single_stop: assert property (@(posedge clk) disable iff (srst)
        (finish && count_reg[ch_reg] == CNT_ZERO && !cfg_reg[ch_reg].rpt && !wr_acc)
        |=> !cfg_reg[$past(ch_reg)].en)
        else $error("single mode channel still enabled after underflow");

    a_repeat_load: assert property (@(posedge clk) disable iff (srst)
        (finish && count_reg[ch_reg] == CNT_ZERO && cfg_reg[ch_reg].rpt && !wr_acc)
        |=> (count_reg[$past(ch_reg)] == $past(reload_reg[ch_reg]) && cfg_reg[$past(ch_reg)].en))
        else $error("repeat mode did not reload or lost enable");

    a_irq_cause: assert property (@(posedge clk) disable iff (srst)
        done_reg[0] |-> $past(finish && ch_reg == 1'b0 && count_reg[0] == CNT_ZERO))
        else $error("completion request without underflow");

    a_window_skip: assert property (@(posedge clk) disable iff (srst)
        cmd_reg.req |-> !(cmd_reg.addr >= WIN_LO && cmd_reg.addr <= WIN_HI))
        else $error("access issued into controller window");

    a_yield_gap: assert property (@(posedge clk) disable iff (srst)
        finish |=> (state_reg == ST_YIELD && !cmd_reg.req) ##1 !cmd_reg.req)
        else $error("bus not returned after a unit");

    a_fixed_lock: assert property (@(posedge clk) disable iff (srst)
        (cfg_reg[0].en && !cfg_reg[0].src_fwd) |=> $stable(src_reg[0]) || $past(wr_acc && !cfg_reg[0].en))
        else $error("fixed source written while enabled");

    a_count_step: assert property (@(posedge clk) disable iff (srst)
        (finish && count_reg[ch_reg] != CNT_ZERO) |=>
        count_reg[$past(ch_reg)] == $past(count_reg[ch_reg]) - CNT_ONE)
        else $error("counter not decremented by one");

    a_req_clear: assert property (@(posedge clk) disable iff (srst)
        (start && !req_event[start_ch]) |=> !reqbit_reg[$past(start_ch)])
        else $error("request bit not cleared at transfer start");
endmodule

// ===== hw/dma_pkg.sv
// Constants, register map and carrier types of the two-channel DMA controller.
// Assumes a single 10 MHz clock domain and an APB register port with 8 address bits.
// Functional notes
// - Two channels steal shared bus cycles
// - Software bit or interrupt signal requests
// - Enabled channel transfers once per request
// - Forward-to-fixed, fixed-to-forward, fixed-to-fixed in 1M
// - Own register window is never accessed
// - Counter covers 65536 units per run
// - Per-channel selectable request source
// - Channel zero wins simultaneous requests
// - Unit is one byte or one word
// - Single mode underflow clears enable
// - Repeat mode underflow reloads, stays active
// - Completion request pulses on underflow
// - First transfer loads pointer and counter
// - Fixed pointers writable only when disabled
// - Enabled forward pointer reads live value
// - Request bit sets always, clears at start
// - Rewriting enable one restarts channel
// - Bus returns to CPU between channels
// - Odd-address word uses two byte cycles
package dma_pkg;
    localparam int NUM_CH     = 2;
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int CNT_W      = 16;
    localparam int NUM_PERIPH = 21;
    localparam int SEL_W      = 5;
    localparam int PADDR_W    = 8;

    // Controller register window that transfers must skip
    localparam logic [ADDR_W-1:0] WIN_LO = 20'h0_0020;
    localparam logic [ADDR_W-1:0] WIN_HI = 20'h0_003F;

    // APB map: bit 5 picks the channel, bits 4:0 the register
    localparam int CH_BIT = 5;
    localparam logic [4:0] OFF_CTRL   = 5'h00;
    localparam logic [4:0] OFF_SEL    = 5'h04;
    localparam logic [4:0] OFF_SRC    = 5'h08;
    localparam logic [4:0] OFF_DST    = 5'h0C;
    localparam logic [4:0] OFF_RELOAD = 5'h10;
    localparam logic [4:0] OFF_COUNT  = 5'h14;

    // Control register bit positions
    localparam int CTRL_EN   = 0;
    localparam int CTRL_RPT  = 1;
    localparam int CTRL_BYTE = 2;
    localparam int CTRL_SFWD = 3;
    localparam int CTRL_DFWD = 4;
    localparam int CTRL_REQ  = 5;
    localparam int CTRL_SWT  = 6;

    // Request source codes
    localparam logic [SEL_W-1:0] SEL_SW          = 5'h00;
    localparam logic [SEL_W-1:0] SEL_PIN0_FALL   = 5'h01;
    localparam logic [SEL_W-1:0] SEL_PIN0_BOTH   = 5'h02;
    localparam logic [SEL_W-1:0] SEL_PIN1_FALL   = 5'h03;
    localparam logic [SEL_W-1:0] SEL_PIN1_BOTH   = 5'h04;
    localparam logic [SEL_W-1:0] SEL_PERIPH_BASE = 5'h05;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h0_0000;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h0_0001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 20'h0_0002;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
    localparam logic [31:0]       RD_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic              en;
        logic              rpt;
        logic              byte_mode;
        logic              src_fwd;
        logic              dst_fwd;
    } chan_cfg_t;

    localparam chan_cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic              req;
        logic              we;
        logic              byte_mode;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_cmd_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_YIELD} xfer_state_t;
endpackage

// ===== hw/dma_req_select.sv
// Request source selector for one channel: synchronises the external
// interrupt pins and turns the selected source into a one-cycle event.
// Peripheral requests and the software trigger are one-cycle pulses on clk.
`timescale 1ns/100ps
module dma_req_select
    import dma_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // Sources
    input  wire logic [SEL_W-1:0]      sel,
    input  wire logic                  ext_irq_pin_zero,
    input  wire logic                  ext_irq_pin_one,
    input  wire logic [NUM_PERIPH-1:0] periph_irq,
    input  wire logic                  sw_trig,
    // Selected event
    output logic                       req_event
);
    logic [1:0] pin_raw;
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] last_reg;
    logic [1:0] fall;
    logic [1:0] both;
    logic [SEL_W-1:0] periph_idx;

    assign pin_raw = {ext_irq_pin_one, ext_irq_pin_zero};

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pin
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_reg[p] <= 1'b1;
                    sync_reg[p] <= 1'b1;
                    last_reg[p] <= 1'b1;
                end else begin
                    meta_reg[p] <= pin_raw[p];
                    sync_reg[p] <= meta_reg[p];
                    last_reg[p] <= sync_reg[p];
                end
            end
            assign fall[p] = last_reg[p] & ~sync_reg[p];
            assign both[p] = last_reg[p] ^ sync_reg[p];
        end
    endgenerate

    assign periph_idx = sel - SEL_PERIPH_BASE;

    // One source per channel; software trigger or interrupt signal
    always_comb begin
        case (sel)
            SEL_SW:        req_event = sw_trig;
            SEL_PIN0_FALL: req_event = fall[0];
            SEL_PIN0_BOTH: req_event = both[0];
            SEL_PIN1_FALL: req_event = fall[1];
            SEL_PIN1_BOTH: req_event = both[1];
            default:       req_event = (32'(periph_idx) < NUM_PERIPH) ? periph_irq[periph_idx] : 1'b0;
        endcase
    end
endmodule

// ===== tb/dma_ctrl_tb.sv
// Testbench of the two-channel DMA controller: APB master, memory model, CPU handshake.
// Assumes zero-wait APB and a one-cycle done_irq pulse per underflow.
`timescale 1ns/100ps
module dma_ctrl_tb;
    import dma_pkg::*;
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, mem_ack;
    logic cpu_bus_req = 0, cpu_cycle_done = 0, slow = 0, err, pin_zero = 1, pin_one = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [NUM_PERIPH-1:0] periph_irq = '0;
    logic [DATA_W-1:0] mem_rdata;
    logic [NUM_CH-1:0] done_irq;
    mem_cmd_t mem_cmd;
    int num_errors = 0, n_tests = 0;
    initial forever #50 clk = ~clk;
    dma_ctrl i_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin_zero(pin_zero), .ext_irq_pin_one(pin_one), .periph_irq(periph_irq), .mem_cmd(mem_cmd),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cpu_bus_req(cpu_bus_req),
        .cpu_cycle_done(cpu_cycle_done), .done_irq(done_irq));
    dma_mem_model i_mem (.clk(clk), .slow(slow), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task automatic pulse(input int b);
        periph_irq[b] <= 1'b1;
        @(posedge clk) periph_irq[b] <= 1'b0;
    endtask
    task automatic wait_done(input int ch);
        for (int i = 0; i < 300 && done_irq[ch] !== 1'b1; i++) @(posedge clk);
        `CHK("done_irq", 1'b1, done_irq[ch])
    endtask
    task automatic t_regs;
        apb(0, 8'h00, 0); `CHK("ctrl0 reset", 32'h0000_0000, rd)
        apb(0, 8'h18, 0); `CHK("unmapped err", 1'b1, err)
        $display("t_regs done");
    endtask
    task automatic t_single_word;
        slow <= 1;
        apb(1, 8'h04, 32'h0000_0005); apb(1, 8'h08, 32'h0000_0100);
        apb(1, 8'h0C, 32'h0000_0300); apb(1, 8'h10, 32'h0000_0001);
        apb(1, 8'h00, 32'h0000_0009);
        apb(1, 8'h0C, 32'h0000_03F0); apb(0, 8'h0C, 0); `CHK("fixed locked", 32'h0000_0300, rd)
        pulse(0); repeat (30) @(posedge clk); pulse(0); wait_done(0); repeat (3) @(posedge clk);
        `CHK("word lo", 8'h02, i_mem.mem[10'h300])
        `CHK("word hi", 8'h03, i_mem.mem[10'h301])
        apb(0, 8'h00, 0); `CHK("single off", 32'h0000_0008, rd)
        $display("t_single_word done");
    endtask
    task automatic t_priority;
        slow <= 0; cpu_bus_req <= 1;
        apb(1, 8'h04, 32'h0000_0006); apb(1, 8'h08, 32'h0000_0010); apb(1, 8'h0C, 32'h0000_0380);
        apb(1, 8'h10, 0); apb(1, 8'h00, 32'h0000_0017);
        apb(1, 8'h08, 32'h0000_0077); apb(0, 8'h08, 0); `CHK("src locked", 32'h0000_0010, rd)
        apb(1, 8'h24, 32'h0000_0006); apb(1, 8'h28, 32'h0000_0011); apb(1, 8'h2C, 32'h0000_0390);
        apb(1, 8'h30, 0); apb(1, 8'h20, 32'h0000_0015);
        pulse(1); wait_done(0);
        repeat (5) @(posedge clk);
        `CHK("ch1 waits cpu", 8'h90, i_mem.mem[10'h390])
        cpu_cycle_done <= 1;
        @(posedge clk) cpu_cycle_done <= 0;
        wait_done(1); repeat (3) @(posedge clk);
        `CHK("ch0 byte", 8'h10, i_mem.mem[10'h380])
        `CHK("ch1 byte", 8'h11, i_mem.mem[10'h390])
        apb(0, 8'h00, 0); `CHK("repeat on", 32'h0000_0017, rd)
        apb(0, 8'h0C, 0); `CHK("live ptr", 32'h0000_0381, rd)
        cpu_bus_req <= 0; apb(1, 8'h0C, 32'h0000_03C0); apb(1, 8'h00, 32'h0000_0017);
        pulse(1); wait_done(0); repeat (3) @(posedge clk);
        `CHK("restart", 8'h10, i_mem.mem[10'h3C0])
        apb(0, 8'h0C, 0); `CHK("reload ptr", 32'h0000_03C1, rd)
        apb(0, 8'h20, 0); `CHK("req while off", 32'h0000_0034, rd)
        $display("t_priority done");
    endtask
    task automatic t_pin_soft;
        apb(1, 8'h24, 32'h0000_0000); apb(1, 8'h28, 32'h0000_0012); apb(1, 8'h2C, 32'h0000_0030);
        apb(1, 8'h20, 32'h0000_0045); wait_done(1); repeat (3) @(posedge clk);
        `CHK("window skip", 8'h30, i_mem.mem[10'h030])
        apb(1, 8'h24, 32'h0000_0003); apb(1, 8'h28, 32'h0000_0203); apb(1, 8'h2C, 32'h0000_03A1);
        apb(1, 8'h20, 32'h0000_0011); pin_zero <= 0; repeat (20) @(posedge clk);
        `CHK("other pin", 8'hA1, i_mem.mem[10'h3A1])
        pin_one <= 0; wait_done(1); repeat (3) @(posedge clk);
        `CHK("split lo", 8'h03, i_mem.mem[10'h3A1])
        `CHK("split hi", 8'h04, i_mem.mem[10'h3A2])
        $display("t_pin_soft done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        t_regs; t_single_word; t_priority; t_pin_soft;
        stop_test;
    end
    initial begin
        #(20000 * 100);
        num_errors++;
        stop_test;
    end
endmodule

// ===== tb/dma_mem_model.sv
// Partner model: memory behind the stolen bus, answering each request with one ack.
// Assumes requests hold until mem_ack and byte data sits in bits 7:0.
`timescale 1ns/100ps
module dma_mem_model
    import dma_pkg::*;
(
    // Clock and pacing
    input  wire logic         clk,
    input  wire logic         slow,
    // Stolen bus
    input  wire mem_cmd_t     mem_cmd,
    output logic [DATA_W-1:0] mem_rdata,
    output logic              mem_ack
);
    logic [7:0] mem [1024];
    int         wait_n = 0;
    initial begin
        mem_ack   = 1'b0;
        mem_rdata = 16'h0000;
        for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
    end
    // Read data toggles outside an ack so stale data never looks valid
    always @(posedge clk) begin
        mem_ack   <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_cmd.req && !mem_ack) begin
            if (slow && wait_n < 3) begin
                wait_n <= wait_n + 1;
            end else begin
                wait_n  <= 0;
                mem_ack <= 1'b1;
                if (mem_cmd.we) begin
                    mem[mem_cmd.addr[9:0]] <= mem_cmd.wdata[7:0];
                    if (!mem_cmd.byte_mode)
                        mem[mem_cmd.addr[9:0] + 10'h001] <= mem_cmd.wdata[15:8];
                end else begin
                    mem_rdata <= {mem[mem_cmd.addr[9:0] + 10'h001], mem[mem_cmd.addr[9:0]]};
                end
            end
        end
    end
endmodule
